// ---- gpio_irq_pkg.sv ----
// Constants for the per-pin interrupt and mode-select logic of an eight-pin port.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one clock domain.
package gpio_irq_pkg;
    localparam int unsigned PIN_COUNT = 8;
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_SENSE = 12'h404;
    localparam logic [ADDR_W-1:0] OFS_BOTH = 12'h408;
    localparam logic [ADDR_W-1:0] OFS_POLARITY = 12'h40c;
    localparam logic [ADDR_W-1:0] OFS_UNMASK = 12'h410;
    localparam logic [ADDR_W-1:0] OFS_RAW = 12'h414;
    localparam logic [ADDR_W-1:0] OFS_MASKED = 12'h418;
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 12'h41c;
    localparam logic [ADDR_W-1:0] OFS_HW_SEL = 12'h420;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Lines 0..4 of this port carry the debug port and start in hardware mode.
    localparam logic [7:0] RST_HW_SEL = 8'h1f;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RESP = 2'b01
    } bus_state_t;
endpackage : gpio_irq_pkg

// ---- gpio_irq_port.sv ----
// Interrupt detection, masking, status and line mode select for an eight-pin port.
// Assumes an Avalon-MM master on mclk; pins are asynchronous and are synchronised here.
// Overview of operation
// - Polarity one selects rising or high.
// - Polarity, unmask, raw status reset to zero.
// - Unmasked pin drives own and combined interrupt.
// - Masked pin drives no interrupt at all.
// - Raw status shows met trigger, ignoring mask.
// - Masked status is raw status after masking.
// - Masked status zero when idle or masked.
// - Clear write of one resets edge latch.
// - Clear write of zero changes nothing.
// - Mode bit one gives line to hardware.
// - Debug lines reset in hardware mode.
// - Any reset restores default mode settings.
// - Sense zero detects edges, one levels.
// - Both-edges bit overrides polarity for edges.
module gpio_irq_port (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [gpio_irq_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] pin_in,
    output logic [7:0] hw_control_bits,
    output logic [7:0] pin_irq,
    output logic combined_port_irq
);
    import gpio_irq_pkg::*;

    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] prev_reg;
    logic [7:0] sense_bits;
    logic [7:0] both_edge_bits;
    logic [7:0] polarity_bits;
    logic [7:0] unmask_bits;
    logic [7:0] edge_latch_reg;
    logic [7:0] edge_latch_next;
    logic [7:0] raw_status_bits;
    logic [7:0] masked_status_bits;
    logic [31:0] rdata_next;
    bus_state_t bus_reg;

    // Reads and writes take one wait cycle so readdata can come from a flop.
    wire bus_req = avs_read | avs_write;
    wire take_req = bus_req && (bus_reg == BUS_IDLE);
    // Writes are stored on the answer edge, where the master sees waitrequest low.
    wire commit_req = bus_req && (bus_reg == BUS_RESP);
    wire wr_lane0 = commit_req && avs_write && avs_byteenable[0];
    wire wr_sense = wr_lane0 && (avs_address == OFS_SENSE);
    wire wr_both = wr_lane0 && (avs_address == OFS_BOTH);
    wire wr_pol = wr_lane0 && (avs_address == OFS_POLARITY);
    wire wr_unmask = wr_lane0 && (avs_address == OFS_UNMASK);
    wire wr_clear = wr_lane0 && (avs_address == OFS_CLEAR);
    wire wr_hw = wr_lane0 && (avs_address == OFS_HW_SEL);

    wire [7:0] rise = sync2_reg & ~prev_reg;
    wire [7:0] fall = ~sync2_reg & prev_reg;
    // Edges qualify by polarity unless both edges are enabled.
    wire [7:0] edge_hit = both_edge_bits & (rise | fall) | ~both_edge_bits & (polarity_bits & rise | ~polarity_bits & fall);
    wire [7:0] level_hit = ~(sync2_reg ^ polarity_bits);
    wire [7:0] clear_bits = wr_clear ? avs_writedata[7:0] : RST_ZERO;

    // A new edge in the clearing cycle survives the clear.
    assign edge_latch_next = (edge_latch_reg & ~clear_bits) | (edge_hit & ~sense_bits);
    assign raw_status_bits = (sense_bits & level_hit) | (~sense_bits & edge_latch_reg);
    assign masked_status_bits = raw_status_bits & unmask_bits;

    wire [7:0] rsel_sense = (avs_address == OFS_SENSE) ? sense_bits : RST_ZERO;
    wire [7:0] rsel_both = (avs_address == OFS_BOTH) ? both_edge_bits : RST_ZERO;
    wire [7:0] rsel_pol = (avs_address == OFS_POLARITY) ? polarity_bits : RST_ZERO;
    wire [7:0] rsel_unm = (avs_address == OFS_UNMASK) ? unmask_bits : RST_ZERO;
    wire [7:0] rsel_raw = (avs_address == OFS_RAW) ? raw_status_bits : RST_ZERO;
    wire [7:0] rsel_mis = (avs_address == OFS_MASKED) ? masked_status_bits : RST_ZERO;
    wire [7:0] rsel_hw = (avs_address == OFS_HW_SEL) ? hw_control_bits : RST_ZERO;
    // Unmapped offsets and the clear register read as zero.
    assign rdata_next = {24'h00_0000, rsel_sense | rsel_both | rsel_pol | rsel_unm | rsel_raw | rsel_mis | rsel_hw};

    always_ff @(posedge mclk) begin
        sync1_reg <= pin_in;
        sync2_reg <= sync1_reg;
        prev_reg <= sync2_reg;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sense_bits <= RST_ZERO;
            both_edge_bits <= RST_ZERO;
            polarity_bits <= RST_ZERO;
            unmask_bits <= RST_ZERO;
            edge_latch_reg <= RST_ZERO;
            hw_control_bits <= RST_HW_SEL;
        end else begin
            if (wr_sense) sense_bits <= avs_writedata[7:0];
            if (wr_both) both_edge_bits <= avs_writedata[7:0];
            if (wr_pol) polarity_bits <= avs_writedata[7:0];
            if (wr_unmask) unmask_bits <= avs_writedata[7:0];
            if (wr_hw) hw_control_bits <= avs_writedata[7:0];
            edge_latch_reg <= edge_latch_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pin_irq <= RST_ZERO;
            combined_port_irq <= 1'b0;
        end else begin
            pin_irq <= masked_status_bits;
            combined_port_irq <= |masked_status_bits;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bus_reg <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= READ_ZERO;
        end else begin
            case (bus_reg)
                BUS_IDLE: begin
                    if (bus_req) begin
                        bus_reg <= BUS_RESP;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= avs_read ? rdata_next : READ_ZERO;
                    end else begin
                        avs_waitrequest <= 1'b1;
                    end
                end
                default: begin
                    bus_reg <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    irq_gate_a: assert property (combined_port_irq == |(pin_irq))
        else $error("combined interrupt disagrees with pin interrupts");
    mask_block_a: assert property (##1 $past(unmask_bits) == 8'h00 |-> pin_irq == 8'h00)
        else $error("masked pin raised interrupt");
    raw_mask_a: assert property (masked_status_bits == (raw_status_bits & unmask_bits))
        else $error("masked status not raw and mask");
    mis_idle_a: assert property ((masked_status_bits & ~raw_status_bits) == 8'h00)
        else $error("masked status without raw status");
    clear_one_a: assert property (wr_clear && avs_writedata[0] && !sense_bits[0] && !edge_hit[0] |=> !edge_latch_reg[0])
        else $error("clear did not drop edge latch");
    clear_zero_a: assert property (wr_clear && !avs_writedata[1] && edge_latch_reg[1] |=> edge_latch_reg[1])
        else $error("zero clear changed edge latch");
    hw_write_a: assert property (wr_hw |=> hw_control_bits == $past(avs_writedata[7:0]))
        else $error("mode select did not load");
    hw_reset_a: assert property (@(posedge mclk) disable iff (1'b0)
        !rst_b |=> hw_control_bits == RST_HW_SEL)
        else $error("debug lines not in hardware mode after reset");
    level_follow_a: assert property (sense_bits[2] && sync2_reg[2] == polarity_bits[2] |-> raw_status_bits[2])
        else $error("level status not following pin");
    edge_hold_a: assert property (!sense_bits[3] && edge_latch_reg[3] && !clear_bits[3] |=> edge_latch_reg[3] || sense_bits[3])
        else $error("edge latch lost without clear");
    bus_answer_a: assert property (take_req |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle");

    edge_seen_c: cover property (!sense_bits[0] && edge_latch_reg[0] ##1 wr_clear);
    level_seen_c: cover property (sense_bits[1] && raw_status_bits[1] && unmask_bits[1]);
    irq_rise_c: cover property (!combined_port_irq ##1 combined_port_irq);
    both_edge_c: cover property (both_edge_bits[0] && fall[0]);
    clear_race_c: cover property (edge_hit[0] && clear_bits[0] && !sense_bits[0]);

    // Register stores land on the edge at which the master sees waitrequest low.
    // Storing any earlier would let a write that is still pending change the block
    // before the master has counted it as done.
    sense_load_a: assert property (
        wr_sense |=> sense_bits == $past(avs_writedata[7:0]))
        else $error("sense select did not load");

    both_load_a: assert property (
        wr_both |=> both_edge_bits == $past(avs_writedata[7:0]))
        else $error("both-edges select did not load");

    pol_load_a: assert property (
        wr_pol |=> polarity_bits == $past(avs_writedata[7:0]))
        else $error("polarity did not load");

    unmask_load_a: assert property (
        wr_unmask |=> unmask_bits == $past(avs_writedata[7:0]))
        else $error("unmask did not load");

    // The status registers are read-only; a write aimed at them must leave all
    // configuration alone.
    ro_write_a: assert property (
        commit_req && avs_write && avs_address == OFS_RAW |=> $stable(unmask_bits))
        else $error("write to raw status disturbed the mask");

    raw_read_a: assert property (
        take_req && avs_read && avs_address == OFS_RAW
            |=> avs_readdata == {24'h00_0000, $past(raw_status_bits)})
        else $error("raw status read back wrong");

    mis_read_a: assert property (
        take_req && avs_read && avs_address == OFS_MASKED
            |=> avs_readdata == {24'h00_0000, $past(masked_status_bits)})
        else $error("masked status read back wrong");

    // The clear register has nothing to show; reading it must not leak latch state.
    clr_read_a: assert property (
        take_req && avs_read && avs_address == OFS_CLEAR |=> avs_readdata == READ_ZERO)
        else $error("clear register read not zero");

    hw_read_a: assert property (
        take_req && avs_read && avs_address == OFS_HW_SEL
            |=> avs_readdata == {24'h00_0000, $past(hw_control_bits)})
        else $error("mode select read back wrong");

    unm_read_a: assert property (
        take_req && avs_read && avs_address == OFS_UNMASK
            |=> avs_readdata == {24'h00_0000, $past(unmask_bits)})
        else $error("unmask read back wrong");

    pol_read_a: assert property (
        take_req && avs_read && avs_address == OFS_POLARITY
            |=> avs_readdata == {24'h00_0000, $past(polarity_bits)})
        else $error("polarity read back wrong");

    sense_read_a: assert property (
        take_req && avs_read && avs_address == OFS_SENSE
            |=> avs_readdata == {24'h00_0000, $past(sense_bits)})
        else $error("sense select read back wrong");

    both_read_a: assert property (
        take_req && avs_read && avs_address == OFS_BOTH
            |=> avs_readdata == {24'h00_0000, $past(both_edge_bits)})
        else $error("both-edges select read back wrong");

    // Offsets past the mode register are holes and must read as zero.
    hole_read_a: assert property (
        take_req && avs_read && avs_address == (OFS_HW_SEL + 12'h004)
            |=> avs_readdata == READ_ZERO)
        else $error("unmapped offset read not zero");

    rd_upper_a: assert property (
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    wait_once_a: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("answer cycle lasted more than one cycle");

    rsp_idle_a: assert property (
        bus_reg == BUS_RESP |=> bus_reg == BUS_IDLE)
        else $error("bus state stuck in answer");

    // Level pins report the live level only; a stale edge latch must not leak in.
    level_only_a: assert property (
        (raw_status_bits & sense_bits) == (level_hit & sense_bits))
        else $error("level pin status not live level");

    edge_only_a: assert property (
        (raw_status_bits & ~sense_bits) == (edge_latch_reg & ~sense_bits))
        else $error("edge pin status not latch");

    // The combined line and the pin lines are one cycle behind masked status.
    irq_follow_a: assert property (
        ##1 pin_irq == $past(masked_status_bits))
        else $error("pin interrupts not following masked status");

    irq_quiet_a: assert property (
        unmask_bits == 8'h00 |=> !combined_port_irq)
        else $error("combined line high with every pin masked");

    // A clear of one pin must leave every other pin's latch where it was.
    clear_other_a: assert property (
        wr_clear && avs_writedata[7:0] == 8'h01 && edge_latch_reg[7] |=> edge_latch_reg[7])
        else $error("clear of pin zero dropped another latch");

    // Counts cycles in which a held request waits; the design inserts one wait state.
    logic [1:0] stall_cnt_reg;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            stall_cnt_reg <= 2'b00;
        end else if (bus_req && avs_waitrequest && stall_cnt_reg != 2'b11) begin
            stall_cnt_reg <= stall_cnt_reg + 2'b01;
        end else if (!bus_req || !avs_waitrequest) begin
            stall_cnt_reg <= 2'b00;
        end
    end

    stall_cap_a: assert property (
        stall_cnt_reg <= 2'b01)
        else $error("bus request waited more than one cycle");

    // Each pin runs the same detector, so one loop checks all eight in turn.
    for (genvar gi = 0; gi < PIN_COUNT; gi++) begin : g_pin_chk
        rise_pick_a: assert property (
            !sense_bits[gi] && !both_edge_bits[gi] && polarity_bits[gi] && rise[gi]
                |=> edge_latch_reg[gi])
            else $error("rising edge not latched");

        fall_pick_a: assert property (
            !sense_bits[gi] && !both_edge_bits[gi] && !polarity_bits[gi] && fall[gi]
                |=> edge_latch_reg[gi])
            else $error("falling edge not latched");

        // The opposite edge must not set a latch that was empty.
        wrong_edge_a: assert property (
            !both_edge_bits[gi] && polarity_bits[gi] && fall[gi] && !edge_latch_reg[gi]
                |=> !edge_latch_reg[gi])
            else $error("wrong edge latched");

        both_pick_a: assert property (
            !sense_bits[gi] && both_edge_bits[gi] && (rise[gi] || fall[gi])
                |=> edge_latch_reg[gi])
            else $error("edge not latched in both-edges mode");

        level_drop_a: assert property (
            sense_bits[gi] && sync2_reg[gi] != polarity_bits[gi] |-> !raw_status_bits[gi])
            else $error("level status set with pin inactive");

        pin_mask_a: assert property (
            !unmask_bits[gi] |=> !pin_irq[gi])
            else $error("masked pin drove its interrupt");

        pin_raise_a: assert property (
            masked_status_bits[gi] |=> pin_irq[gi])
            else $error("unmasked pin did not raise its interrupt");

        // Outside reset, only a mode register write may move a line between software and hardware.
        hw_hold_a: assert property (
            !wr_hw |=> $stable(hw_control_bits[gi]))
            else $error("mode select moved without a write");

        clr_pick_a: assert property (
            wr_clear && avs_writedata[gi] && !edge_hit[gi] |=> !edge_latch_reg[gi])
            else $error("clear of one did not drop latch");

        clr_keep_a: assert property (
            wr_clear && !avs_writedata[gi] && edge_latch_reg[gi] |=> edge_latch_reg[gi])
            else $error("clear of zero dropped latch");
    end
endmodule : gpio_irq_port

// ---- pin_model.sv ----
// Behavioural model of the eight external port pins.
// Assumes the bench asks for a pin level pattern on mclk.
module pin_model (
    input wire logic mclk,
    input wire logic [7:0] want,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin_in = 8'h00;
    // Pins move only after an edge, so the synchroniser sees clean steps.
    always @(posedge mclk) pin_in <= want;
endmodule : pin_model

// ---- tb.sv ----
// Self-checking bench for the port interrupt and mode-select block.
// Assumes a single 100 MHz clock and the pin model beside the block.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t: got %h want %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_irq_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, combined_port_irq;
    logic [7:0] want = 8'h00;
    logic [7:0] pin_in, hw_control_bits, pin_irq, m, p, c, pol;
    int seed = 32'h31ba7315;
    int err_count = 0;
    int n_checks = 0;
    always #5 mclk = ~mclk;
    pin_model i_pin_model (.mclk(mclk), .want(want), .pin_in(pin_in));
    gpio_irq_port i_gpio_irq_port (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
        .hw_control_bits(hw_control_bits), .pin_irq(pin_irq),
        .combined_port_irq(combined_port_irq));
    function automatic logic [7:0] lvl(input logic [7:0] v, input logic [7:0] s);
        return ~(v ^ s);
    endfunction : lvl
    task stop_test;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) begin err_count++; stop_test(); end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(q, {24'h00_0000, e})
    endtask : rd
    task automatic pins(input logic [7:0] v);
        want <= v;
        repeat (8) @(posedge mclk);
    endtask : pins
    initial begin
        fork begin repeat (100000) @(posedge mclk); err_count++; stop_test(); end join_none
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        rd(OFS_POLARITY, RST_ZERO);
        rd(OFS_UNMASK, RST_ZERO);
        rd(OFS_RAW, RST_ZERO);
        rd(OFS_SENSE, RST_ZERO);
        rd(OFS_HW_SEL, RST_HW_SEL);
        rd(12'h424, RST_ZERO);
        $display("reset values done");
        m = 8'($random(seed));
        bus(1'b1, OFS_POLARITY, 32'h0000_00ff);
        bus(1'b1, OFS_UNMASK, {24'h00_0000, m});
        pins(8'hff);
        bus(1'b1, OFS_RAW, 32'h0000_0000);
        rd(OFS_RAW, 8'hff);
        rd(OFS_MASKED, m);
        `CHK(pin_irq, m)
        `CHK(combined_port_irq, |m)
        c = 8'($random(seed));
        bus(1'b1, OFS_CLEAR, {24'h00_0000, c});
        rd(OFS_RAW, ~c);
        bus(1'b1, OFS_CLEAR, 32'h0000_00ff);
        pins(8'h00);
        rd(OFS_RAW, RST_ZERO);
        $display("edge latch done");
        p = 8'($random(seed));
        bus(1'b1, OFS_POLARITY, 32'h0000_0000);
        bus(1'b1, OFS_BOTH, 32'h0000_00ff);
        pins(p);
        rd(OFS_RAW, p);
        bus(1'b1, OFS_BOTH, 32'h0000_0000);
        bus(1'b1, OFS_CLEAR, 32'h0000_00ff);
        pol = 8'($random(seed));
        bus(1'b1, OFS_POLARITY, {24'h00_0000, pol});
        bus(1'b1, OFS_SENSE, 32'h0000_00ff);
        repeat (4) begin
            p = 8'($random(seed));
            pins(p);
            rd(OFS_RAW, lvl(p, pol));
            rd(OFS_MASKED, lvl(p, pol) & m);
            `CHK(combined_port_irq, |(lvl(p, pol) & m))
        end
        $display("level sense done");
        c = 8'($random(seed));
        bus(1'b1, OFS_HW_SEL, {24'h00_0000, c});
        rd(OFS_HW_SEL, c);
        `CHK(hw_control_bits, c)
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        `CHK(hw_control_bits, RST_HW_SEL)
        `CHK(combined_port_irq, 1'b0)
        rd(OFS_UNMASK, RST_ZERO);
        $display("mode select done");
        stop_test();
    end
endmodule : tb
